/* core/smdc_pkg.sv */
/*
 * Shared constants and types for the supply margining code control block.
 * Assumes a single 50 MHz core clock and a host that writes over a plain,
 * same-clock write port.
 */
package smdc_pkg;

    localparam int NUM_CH = 6;
    localparam int CODE_W = 8;
    localparam int CH_W = 3;
    localparam logic [CODE_W-1:0] MIDCODE = 8'h7F;

    localparam int CFG_RANGE_LSB = 0;
    localparam int CFG_ENABLE_BIT = 2;

    localparam int CLK_PERIOD_NS = 20;
    localparam int FOLLOW_TIME_NS = 1000;
    localparam int FOLLOW_CYCLES =
        (FOLLOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Midcode voltage selected by the two range bits, in this order.
    typedef enum logic [1:0] {
        RANGE_MID_0V60,
        RANGE_MID_0V80,
        RANGE_MID_1V00,
        RANGE_MID_1V25
    } smdc_range_e;

    typedef enum logic [1:0] {
        WR_CODE,
        WR_UPPER,
        WR_LOWER,
        WR_CFG
    } smdc_wsel_e;

    typedef enum logic [1:0] {
        BUF_OFF,
        BUF_FOLLOW,
        BUF_DRIVE
    } smdc_buf_state_e;

    typedef struct packed {
        logic [CODE_W-1:0] upper;
        logic [CODE_W-1:0] lower;
        logic [1:0] range;
        logic enable;
    } smdc_nv_s;

    typedef struct packed {
        logic valid;
        smdc_wsel_e sel;
        logic [CH_W-1:0] chan;
        logic [CODE_W-1:0] data;
    } smdc_wr_s;

    typedef struct packed {
        logic power;
        logic src_dac;
        logic drive;
    } smdc_buf_s;

endpackage

/* core/smdc_buf_seq.sv */
/*
 * Per-channel output buffer enable sequencer.
 * Assumes enable and hiz come from flip-flops on the same clock and that
 * rst_n is already synchronised.
 */
`timescale 1ns/100ps
module smdc_buf_seq #(
    parameter int FOLLOW_CYCLES = smdc_pkg::FOLLOW_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic hiz,
    output smdc_pkg::smdc_buf_s buf_q
);
    localparam int CNT_W = $clog2(FOLLOW_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FOLLOW_CYCLES - 1);

    if (FOLLOW_CYCLES < 1) begin : g_bad
        $error("FOLLOW_CYCLES must be at least one");
    end

    smdc_pkg::smdc_buf_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic go;

    assign go = enable && !hiz;

    // The pin is only driven after the buffer has tracked it for a while,
    // so the converter sees no step when the output stage turns on.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        unique case (state_q)
            smdc_pkg::BUF_OFF: begin
                cnt_d = '0;
                if (go) begin
                    state_d = smdc_pkg::BUF_FOLLOW;
                end
            end
            smdc_pkg::BUF_FOLLOW: begin
                if (!go) begin
                    state_d = smdc_pkg::BUF_OFF;
                end else if (cnt_q == CNT_LAST) begin
                    state_d = smdc_pkg::BUF_DRIVE;
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            smdc_pkg::BUF_DRIVE: begin
                if (!go) begin
                    state_d = smdc_pkg::BUF_OFF;
                end
            end
            default: begin
                state_d = smdc_pkg::BUF_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= smdc_pkg::BUF_OFF;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= '0;
        end else begin
            buf_q.power <= (state_d != smdc_pkg::BUF_OFF);
            buf_q.src_dac <= (state_d == smdc_pkg::BUF_DRIVE);
            buf_q.drive <= (state_d == smdc_pkg::BUF_DRIVE);
        end
    end

    AST_FOLLOW_FIRST: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(buf_q.drive) |->
            $past(buf_q.power, FOLLOW_CYCLES) && !$past(buf_q.drive)
            && !$past(buf_q.power, FOLLOW_CYCLES + 1))
        else $error("drive began without the full follow phase");

    AST_HIZ_OFF: assert property (
        @(posedge clk) disable iff (!rst_n)
        hiz |=> !buf_q.power && !buf_q.drive)
        else $error("buffer powered while limits are inverted");

endmodule

/* core/smdc_top.sv */
/*
 * Control logic for six supply margining code channels: code and limit
 * storage, clipping, range select, power-up load and buffer sequencing.
 * Assumes the host write port and the nonvolatile image are on core_clk
 * and that the nonvolatile image is stable when reset is released.
 */
`timescale 1ns/100ps
// Overview of operation
// - Six independent channels, each with its own code and output.
// - Two range bits choose midcode 0.6, 0.8, 1.0 or 1.25 V.
// - Output is linear in the unsigned effective code around 0x7F.
// - Eight-bit code, 256 settings, starting at midcode after load.
// - Code passes between limits inclusive, otherwise clipped to nearest limit.
// - Output buffer held off whenever lower limit exceeds upper limit.
// - Limits and configuration load from nonvolatile image at power-up.
// - Buffer first follows the pin undriven, then switches over and drives.
module smdc_top #(
    parameter int NUM_CH = smdc_pkg::NUM_CH,
    parameter int FOLLOW_CYCLES = smdc_pkg::FOLLOW_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input smdc_pkg::smdc_nv_s [NUM_CH-1:0] nv_cfg,
    input smdc_pkg::smdc_wr_s host_wr,
    output logic [NUM_CH-1:0][smdc_pkg::CODE_W-1:0] eff_code_q,
    output logic [NUM_CH-1:0][1:0] range_sel_q,
    output logic [NUM_CH-1:0] hiz_q,
    output smdc_pkg::smdc_buf_s [NUM_CH-1:0] buf_ctl,
    output logic cfg_loaded_q
);
    localparam int CW = smdc_pkg::CODE_W;
    localparam int CHW = smdc_pkg::CH_W;

    if (NUM_CH < 1 || NUM_CH > (1 << CHW)) begin : g_bad
        $error("NUM_CH does not fit the channel select field");
    end

    logic rst_meta_q;
    logic rst_sync_q;
    logic [NUM_CH-1:0][CW-1:0] code_q, code_d;
    logic [NUM_CH-1:0][CW-1:0] upper_q, upper_d;
    logic [NUM_CH-1:0][CW-1:0] lower_q, lower_d;
    logic [NUM_CH-1:0][1:0] range_d;
    logic [NUM_CH-1:0] enable_q, enable_d;
    logic [NUM_CH-1:0][CW-1:0] eff_d;
    logic [NUM_CH-1:0] hiz_d;

    function automatic logic [CW-1:0] clip_code(
        input logic [CW-1:0] code,
        input logic [CW-1:0] lo,
        input logic [CW-1:0] hi
    );
        if (code < lo) begin
            return lo;
        end else if (code > hi) begin
            return hi;
        end
        return code;
    endfunction

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // The load happens in the first cycle after release rather than inside
    // reset, so no flip-flop copies a port under the asynchronous reset.
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            cfg_loaded_q <= 1'b0;
        end else begin
            cfg_loaded_q <= 1'b1;
        end
    end

    always_comb begin
        code_d = code_q;
        upper_d = upper_q;
        lower_d = lower_q;
        range_d = range_sel_q;
        enable_d = enable_q;
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (!cfg_loaded_q) begin
                upper_d[ch] = nv_cfg[ch].upper;
                lower_d[ch] = nv_cfg[ch].lower;
                range_d[ch] = nv_cfg[ch].range;
                enable_d[ch] = nv_cfg[ch].enable;
                code_d[ch] = smdc_pkg::MIDCODE;
            end else if (host_wr.valid && host_wr.chan == CHW'(ch)) begin
                unique case (host_wr.sel)
                    smdc_pkg::WR_CODE: begin
                        code_d[ch] = host_wr.data;
                    end
                    smdc_pkg::WR_UPPER: begin
                        upper_d[ch] = host_wr.data;
                    end
                    smdc_pkg::WR_LOWER: begin
                        lower_d[ch] = host_wr.data;
                    end
                    smdc_pkg::WR_CFG: begin
                        range_d[ch] =
                            host_wr.data[smdc_pkg::CFG_RANGE_LSB +: 2];
                        enable_d[ch] =
                            host_wr.data[smdc_pkg::CFG_ENABLE_BIT];
                    end
                endcase
            end
            // Clipping uses the next values so a write is seen one edge later.
            eff_d[ch] = clip_code(code_d[ch], lower_d[ch], upper_d[ch]);
            hiz_d[ch] = (lower_d[ch] > upper_d[ch]);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            code_q <= '{default: smdc_pkg::MIDCODE};
            upper_q <= '0;
            lower_q <= '0;
        end else begin
            code_q <= code_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            range_sel_q <= '0;
            enable_q <= '0;
        end else begin
            range_sel_q <= range_d;
            enable_q <= enable_d;
        end
    end

    // A reset value of hiz keeps every pin undriven until limits are known.
    always_ff @(posedge core_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            eff_code_q <= '{default: smdc_pkg::MIDCODE};
            hiz_q <= '1;
        end else begin
            eff_code_q <= eff_d;
            hiz_q <= hiz_d;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_sync_q);

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        smdc_buf_seq #(
            .FOLLOW_CYCLES(FOLLOW_CYCLES)
        ) u_seq (
            .clk(core_clk),
            .rst_n(rst_sync_q),
            .enable(enable_q[c]),
            .hiz(hiz_q[c]),
            .buf_q(buf_ctl[c])
        );

        AST_PASS: assert property (
            cfg_loaded_q && code_q[c] >= lower_q[c]
            && code_q[c] <= upper_q[c] |-> eff_code_q[c] == code_q[c])
            else $error("code inside limits was altered");

        AST_CLIP_LOW: assert property (
            cfg_loaded_q && code_q[c] < lower_q[c]
            && lower_q[c] <= upper_q[c] |-> eff_code_q[c] == lower_q[c])
            else $error("code below lower limit not clipped");

        AST_CLIP_HIGH: assert property (
            cfg_loaded_q && code_q[c] > upper_q[c]
            && lower_q[c] <= upper_q[c] |-> eff_code_q[c] == upper_q[c])
            else $error("code above upper limit not clipped");

        AST_INVERTED: assert property (
            cfg_loaded_q && lower_q[c] > upper_q[c]
            |-> hiz_q[c] ##1 !buf_ctl[c].drive)
            else $error("inverted limits did not hold output off");

        AST_NV_LOAD: assert property (
            $rose(cfg_loaded_q) |-> upper_q[c] == $past(nv_cfg[c].upper)
            && lower_q[c] == $past(nv_cfg[c].lower)
            && enable_q[c] == $past(nv_cfg[c].enable)
            && range_sel_q[c] == $past(nv_cfg[c].range))
            else $error("limits not loaded from nonvolatile image");

        AST_HIZ_MATCH: assert property (
            cfg_loaded_q |-> hiz_q[c] == (lower_q[c] > upper_q[c]))
            else $error("three-state flag disagrees with the limits");

        AST_MID_START: assert property (
            $rose(cfg_loaded_q) |-> code_q[c] == smdc_pkg::MIDCODE)
            else $error("code did not start at midcode");

        AST_WR_NEXT: assert property (
            cfg_loaded_q && host_wr.valid && host_wr.chan == CHW'(c)
            && host_wr.sel == smdc_pkg::WR_CODE
            |=> code_q[c] == $past(host_wr.data)
            && eff_code_q[c] == clip_code(code_q[c], lower_q[c], upper_q[c]))
            else $error("code write not applied on the next cycle");

        AST_RANGE: assert property (
            cfg_loaded_q && host_wr.valid && host_wr.chan == CHW'(c)
            && host_wr.sel == smdc_pkg::WR_CFG
            |=> range_sel_q[c]
                == $past(host_wr.data[smdc_pkg::CFG_RANGE_LSB +: 2]))
            else $error("range select write not applied");

        AST_ENABLE: assert property (
            cfg_loaded_q && host_wr.valid && host_wr.chan == CHW'(c)
            && host_wr.sel == smdc_pkg::WR_CFG
            |=> enable_q[c]
                == $past(host_wr.data[smdc_pkg::CFG_ENABLE_BIT]))
            else $error("enable write not applied");
    end

endmodule

/* test/smdc_host_model.sv */
/*
 * Host side model: issues writes on the host write port, each held valid until the next put or idle.
 * Assumes the caller waits for cfg_loaded_q before the first write.
 */
`timescale 1ns/100ps
module smdc_host_model (
    input wire logic clk,
    output smdc_pkg::smdc_wr_s wr
);
    initial wr = '0;

    // A new code for one channel is how the host margins its rail.
    task automatic put(input smdc_pkg::smdc_wsel_e sel,
                       input logic [2:0] ch, input logic [7:0] d);
        @(posedge clk);
        wr <= '{valid: 1'b1, sel: sel, chan: ch, data: d};
    endtask

    // Idle data lines toggle, so a stale byte never looks like a write.
    task automatic idle();
        @(posedge clk);
        wr <= '{valid: 1'b0, sel: wr.sel, chan: wr.chan, data: ~wr.data};
    endtask
endmodule

/* test/smdc_top_test.sv */
/*
 * Self-checking bench for the margining code control block.
 * Assumes the host model as the only writer and a short follow count.
 */
`timescale 1ns/100ps
module smdc_top_test;
    localparam int NC = smdc_pkg::NUM_CH;
    localparam int FP = 3;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    smdc_pkg::smdc_nv_s [NC-1:0] nv_cfg = '0;
    smdc_pkg::smdc_wr_s host_wr;
    logic [NC-1:0][7:0] eff_code_q;
    logic [NC-1:0][1:0] range_sel_q;
    logic [NC-1:0] hiz_q;
    smdc_pkg::smdc_buf_s [NC-1:0] buf_ctl;
    logic cfg_loaded_q;
    logic [7:0] m_code [NC];
    logic [7:0] m_up [NC];
    logic [7:0] m_lo [NC];
    logic [1:0] m_rng [NC];
    logic [7:0] vals [8];
    logic [15:0] exp_q [$];
    logic pend = 1'b0;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    int n;

    initial forever #10 core_clk = ~core_clk;

    smdc_host_model host (.clk(core_clk), .wr(host_wr));

    smdc_top #(.FOLLOW_CYCLES(FP)) DUT (
        .core_clk(core_clk), .nrst(nrst), .nv_cfg(nv_cfg),
        .host_wr(host_wr), .eff_code_q(eff_code_q),
        .range_sel_q(range_sel_q), .hiz_q(hiz_q), .buf_ctl(buf_ctl),
        .cfg_loaded_q(cfg_loaded_q));

    // Code is masked while the limits are inverted, since it never reaches a pin.
    function automatic logic [15:0] ent(int ch);
        logic [7:0] c;
        logic hz;
        hz = m_lo[ch] > m_up[ch];
        c = (m_code[ch] < m_lo[ch]) ? m_lo[ch] :
            ((m_code[ch] > m_up[ch]) ? m_up[ch] : m_code[ch]);
        return {2'b00, 3'(ch), m_rng[ch], hz, hz ? 8'h00 : c};
    endfunction

    function automatic logic [15:0] got(int ch);
        return {2'b00, 3'(ch), range_sel_q[ch], hiz_q[ch],
                hiz_q[ch] ? 8'h00 : eff_code_q[ch]};
    endfunction

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (e !== g) begin
            n_errors++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic send(input smdc_pkg::smdc_wsel_e sel, input int ch,
                        input logic [7:0] d);
        host.put(sel, 3'(ch), d);
        if (ch >= NC) begin
            exp_q.push_back(ent(0));
        end else begin
            case (sel)
                smdc_pkg::WR_CODE: m_code[ch] = d;
                smdc_pkg::WR_UPPER: m_up[ch] = d;
                smdc_pkg::WR_LOWER: m_lo[ch] = d;
                default: m_rng[ch] = d[1:0];
            endcase
            exp_q.push_back(ent(ch));
        end
    endtask

    // Waits for the image load after a reset release, checks every channel.
    task automatic load_check();
        for (int ch = 0; ch < NC; ch++) begin
            m_up[ch] = nv_cfg[ch].upper;
            m_lo[ch] = nv_cfg[ch].lower;
            m_rng[ch] = nv_cfg[ch].range;
            m_code[ch] = smdc_pkg::MIDCODE;
        end
        for (int i = 0; i < 10 && cfg_loaded_q !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chk(16'(cfg_loaded_q), 16'h0001);
        for (int ch = 0; ch < NC; ch++) begin
            chk(ent(ch), got(ch));
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        pend <= host_wr.valid;
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            conclude();
        end
    end

    always @(negedge core_clk) begin
        logic [15:0] e;
        if (pend && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            chk(e, got(int'(e[13:11])));
        end
    end

    initial begin
        void'($urandom(53));
        for (int ch = 0; ch < NC; ch++) begin
            nv_cfg[ch] = 19'($urandom);
        end
        repeat (16) @(posedge core_clk);
        nrst <= 1'b1;
        load_check();
        $display("test power-up load done");
        for (int ch = 0; ch < NC; ch++) begin
            vals[2] = 8'($urandom_range(8'h60, 8'h01));
            vals[4] = 8'($urandom_range(8'hFE, 8'hA0));
            vals = '{8'h00, vals[2] - 8'h01, vals[2], 8'($urandom),
                     vals[4], vals[4] + 8'h01, 8'hFF, smdc_pkg::MIDCODE};
            send(smdc_pkg::WR_LOWER, ch, vals[2]);
            send(smdc_pkg::WR_UPPER, ch, vals[4]);
            send(smdc_pkg::WR_CFG, ch, {6'h00, 2'(ch)});
            for (int k = 0; k < 8; k++) begin
                send(smdc_pkg::WR_CODE, ch, vals[k]);
            end
        end
        send(smdc_pkg::WR_CFG, 3, 8'h03);
        $display("test clipping and ranges done");
        send(smdc_pkg::WR_LOWER, 1, 8'h90);
        send(smdc_pkg::WR_UPPER, 1, 8'h80);
        send(smdc_pkg::WR_UPPER, 1, 8'h90);
        send(smdc_pkg::WR_CODE, 6, 8'h11);
        send(smdc_pkg::WR_CODE, 7, 8'h22);
        $display("test inverted limits and bad channel done");
        for (int ch = 0; ch < NC; ch++) begin
            send(smdc_pkg::WR_CFG, ch, 8'h00);
        end
        send(smdc_pkg::WR_LOWER, 2, 8'h00);
        send(smdc_pkg::WR_UPPER, 2, 8'hFF);
        send(smdc_pkg::WR_CODE, 2, 8'h7F);
        send(smdc_pkg::WR_CFG, 2, 8'h04);
        host.idle();
        for (int i = 0; i < 10 && buf_ctl[2].power !== 1'b1; i++) begin
            @(negedge core_clk);
        end
        chk(16'(buf_ctl[2]), 16'h0004);
        n = 0;
        while (n < 20 && buf_ctl[2].drive !== 1'b1) begin
            @(negedge core_clk);
            n++;
        end
        chk(16'(n), 16'(FP));
        chk(16'(buf_ctl[2]), 16'h0007);
        send(smdc_pkg::WR_LOWER, 2, 8'h01);
        send(smdc_pkg::WR_UPPER, 2, 8'h00);
        host.idle();
        repeat (4) @(negedge core_clk);
        chk(16'(buf_ctl[2]), 16'h0000);
        $display("test buffer sequence done");
        @(posedge core_clk);
        nrst <= 1'b0;
        for (int ch = 0; ch < NC; ch++) begin
            nv_cfg[ch] <= 19'($urandom);
        end
        @(negedge core_clk);
        // Reset shows midcode, every pin three-stated and nothing loaded.
        chk({1'b0, eff_code_q[0], hiz_q, cfg_loaded_q}, 16'h3FFE);
        chk({14'h0000, |range_sel_q, |buf_ctl}, 16'h0000);
        repeat (14) @(posedge core_clk);
        nrst <= 1'b1;
        load_check();
        $display("test reset reload done");
        repeat (3) @(posedge core_clk);
        conclude();
    end
endmodule
